// File: shared/dsf_map.vh
// constants of the diskette sector framer
`ifndef DSF_MAP_VH
`define DSF_MAP_VH
// ----------------------------------------
// geometry
// ----------------------------------------
`define DSF_LAST_TRK 7'd76
`define DSF_SECTORS 5'd26
`define DSF_FIRST_SEC 5'd1
`define DSF_INDEX_TRK 7'd0
`define DSF_REC_LEN 8'd128
`define DSF_GAP_LEN 8'd17
`define DSF_ID_LEN 8'd2
`define DSF_CRC_LEN 8'd2
`define DSF_DM_WAIT 8'd21
// ----------------------------------------
// byte and mark patterns
// ----------------------------------------
`define DSF_IDM_DATA 8'hFE
`define DSF_DM_DATA 8'hFB
`define DSF_MARK_CLK 8'hC7
`define DSF_NORM_CLK 8'hFF
`define DSF_GAP_BYTE 8'hFF
`define DSF_FILL_BYTE 8'h00
// ----------------------------------------
// check characters
// ----------------------------------------
`define DSF_CRC_POLY 16'h1021
`define DSF_CRC_INIT 16'hFFFF
`define DSF_CRC_GOOD 16'h0000
// ----------------------------------------
// timing
// ----------------------------------------
`define DSF_CLK_NS 20
`define DSF_CELL_NS 2000
`define DSF_CELL_CYC ((`DSF_CELL_NS + `DSF_CLK_NS - 1) / `DSF_CLK_NS)
`define DSF_BIT_LAST 4'hF
// cycles to wait after a move before seek ready is believed
`define DSF_SEEK_HOLD 8'd3
// ----------------------------------------
// write buffer
// ----------------------------------------
`define DSF_FIFO_W 9
`define DSF_FIFO_D 4
`define DSF_FIFO_AW 2
`endif

// File: core/dsf_framer.v
// diskette sector framer: fm cell stream to and from the drive, write buffer
`timescale 1ns/10ps
`default_nettype none
`include "dsf_map.vh"
// Operation
// - tracks 00 to 76, outermost is 00
// - 26 sectors per track, numbered 01-26
// - id field precedes data field per sector
// - id holds track, sector; mark before
// - bytes after id mark form id field
// - id field closed by two crc bytes
// - data field is exactly 128 bytes
// - 17-byte gap then data mark precede data
// - data mark means the record is good
// - data field closed by two crc bytes
// - short record padded to full length
// - pad bytes are all zero
// - find sectors by id, any interleave
// - format writes all 2002 sectors, dummy data; track 00 takes buffered data
// - track 00 is index, files from 01
// ----------------------------------------
// write buffer fifo
// ----------------------------------------
module dsf_fifo #(
	parameter W = 9,
	parameter D = 4,
	parameter AW = 2
) (
	input wire clk_sys,
	input wire srst,
	input wire [W-1:0] in_data,
	input wire in_valid,
	output reg in_ready,
	output wire [W-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	localparam [AW:0] FULL = D[AW:0]; // entry count when full
	reg [W-1:0] mem [0:D-1]; // storage
	reg [AW-1:0] wp; // write pointer
	reg [AW-1:0] rp; // read pointer
	reg [AW:0] cnt; // entries held
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	wire [AW:0] next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign out_valid = (cnt != {(AW+1){1'b0}});
	assign out_data = mem[rp];
	// storage write, no reset needed
	always @(posedge clk_sys) begin
		if (push) begin
			mem[wp] <= in_data;
		end
	end
	// pointers, count and registered ready
	always @(posedge clk_sys) begin
		if (srst) begin
			wp <= {AW{1'b0}};
			rp <= {AW{1'b0}};
			cnt <= {(AW+1){1'b0}};
			in_ready <= 1'b1;
		end else begin
			if (push) begin
				wp <= wp + 1'b1;
			end
			if (pop) begin
				rp <= rp + 1'b1;
			end
			cnt <= next_cnt;
			in_ready <= (next_cnt != FULL);
		end
	end
endmodule
// ----------------------------------------
// framer top
// ----------------------------------------
module dsf_framer (
	input wire clk_sys,
	input wire srst,
	input wire cmd_read,
	input wire cmd_write,
	input wire cmd_format,
	input wire cmd_abort,
	input wire [6:0] cmd_trk,
	input wire [4:0] cmd_sec,
	input wire [7:0] in_data,
	input wire in_last,
	input wire in_valid,
	output wire in_ready,
	output reg [7:0] rd_data,
	output reg rd_valid,
	output reg busy,
	output reg done,
	output reg rec_good,
	output reg cmd_err,
	output reg id_crc_err,
	output reg data_crc_err,
	output reg underrun,
	output reg [6:0] seek_trk,
	input wire seek_ready,
	input wire rd_cell,
	output reg wr_cell,
	output reg wr_gate
);
	// one-hot states
	localparam [12:0] S_IDLE = 13'h0001;
	localparam [12:0] S_SEEK = 13'h0002;
	localparam [12:0] S_GAP1 = 13'h0004;
	localparam [12:0] S_IDM = 13'h0008;
	localparam [12:0] S_ID = 13'h0010;
	localparam [12:0] S_IDC = 13'h0020;
	localparam [12:0] S_GAP2 = 13'h0040;
	localparam [12:0] S_DM = 13'h0080;
	localparam [12:0] S_DAT = 13'h0100;
	localparam [12:0] S_DC = 13'h0200;
	localparam [12:0] R_HUNT = 13'h0400;
	localparam [12:0] R_ID = 13'h0800;
	localparam [12:0] R_DAT = 13'h1000;
	localparam integer CELL_CYC = `DSF_CELL_CYC; // cycles per fm half cell
	localparam [6:0] CELL_TOP = CELL_CYC[6:0] - 7'd1; // last divider count
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// interleave clock and data bits, clock first, msb first
	function [15:0] fm_enc;
		input [7:0] c;
		input [7:0] d;
		integer i;
		begin
			fm_enc = 16'h0000;
			for (i = 0; i < 8; i = i + 1) begin
				fm_enc[2*i+1] = c[i];
				fm_enc[2*i] = d[i];
			end
		end
	endfunction
	// pick data bits out of sixteen cells
	function [7:0] fm_dat;
		input [15:0] s;
		integer i;
		begin
			fm_dat = 8'h00;
			for (i = 0; i < 8; i = i + 1) begin
				fm_dat[i] = s[2*i];
			end
		end
	endfunction
	// crc over one byte, msb first
	function [15:0] crc_upd;
		input [15:0] c;
		input [7:0] b;
		integer i;
		reg fb;
		begin
			crc_upd = c;
			for (i = 7; i >= 0; i = i - 1) begin
				fb = crc_upd[15] ^ b[i];
				crc_upd = {crc_upd[14:0], 1'b0} ^ (fb ? `DSF_CRC_POLY : 16'h0000);
			end
		end
	endfunction
	// ----------------------------------------
	// state and datapath registers
	// ----------------------------------------
	reg [13:0] st; // one-hot state, top bit is data mark hunt
	reg [7:0] idx; // byte index within current field
	reg [15:0] crc; // running check value
	reg [15:0] sh; // outgoing cells
	reg [15:0] rx_sh; // incoming cells
	reg [3:0] bcnt; // cell count within a byte
	reg [6:0] div; // cell rate divider
	reg cell_en; // one pulse per half cell
	reg rd_s1; // read cell sync stage one
	reg rd_s2; // read cell sync stage two
	reg sk_s1; // seek ready sync stage one
	reg sk_s2; // seek ready sync stage two
	reg op_rd; // current command reads
	reg op_fmt; // current command formats
	reg pad; // rest of data field is fill
	reg [6:0] cur_trk; // track being handled
	reg [4:0] cur_sec; // sector being handled
	reg [7:0] cap_trk; // track read from id field
	reg [7:0] cap_sec; // sector read from id field
	// data mark hunt uses a fourteenth state bit
	wire hunt_dm = st[13];
	wire wr_st = |st[9:2];
	wire [12:0] st13 = st[12:0];
	// ----------------------------------------
	// write byte sequencer
	// ----------------------------------------
	reg [12:0] nst; // next write state
	reg [7:0] nidx; // next field index
	reg [7:0] ld_byte; // byte to send
	reg [7:0] ld_clk; // clock pattern to send
	reg [15:0] ncrc; // check value after loading
	reg end_sec; // last byte of sector done
	wire [8:0] f_data;
	wire f_valid;
	wire dummy = op_fmt && (cur_trk != `DSF_INDEX_TRK);
	wire fill_now = pad || dummy || !f_valid;
	wire byte_go = cell_en && wr_st && (bcnt == `DSF_BIT_LAST);
	// ready is trusted only once the synchroniser holds a sample taken after the move
	wire seek_ok = (st13 == S_SEEK) && sk_s2 && (idx == `DSF_SEEK_HOLD);
	wire start_wr = seek_ok && !op_rd;
	wire load = byte_go || start_wr;
	wire f_pop = load && (nst == S_DAT) && !fill_now;
	// next field and byte for the write stream
	always @* begin
		nst = st13;
		nidx = idx + 8'd1;
		ld_byte = `DSF_GAP_BYTE;
		ld_clk = `DSF_NORM_CLK;
		ncrc = crc;
		end_sec = 1'b0;
		case (st13)
			S_SEEK: begin
				nst = S_GAP1;
				nidx = 8'd0;
			end
			S_GAP1: if (idx == `DSF_GAP_LEN - 8'd1) begin
				nst = S_IDM;
				nidx = 8'd0;
			end
			S_IDM: begin
				nst = S_ID;
				nidx = 8'd0;
			end
			S_ID: if (idx == `DSF_ID_LEN - 8'd1) begin
				nst = S_IDC;
				nidx = 8'd0;
			end
			S_IDC: if (idx == `DSF_CRC_LEN - 8'd1) begin
				nst = S_GAP2;
				nidx = 8'd0;
			end
			S_GAP2: if (idx == `DSF_GAP_LEN - 8'd1) begin
				nst = S_DM;
				nidx = 8'd0;
			end
			S_DM: begin
				nst = S_DAT;
				nidx = 8'd0;
			end
			S_DAT: if (idx == `DSF_REC_LEN - 8'd1) begin
				nst = S_DC;
				nidx = 8'd0;
			end
			S_DC: if (idx == `DSF_CRC_LEN - 8'd1) begin
				end_sec = 1'b1;
				nidx = 8'd0;
				if (op_fmt && cur_sec != `DSF_SECTORS) begin
					nst = S_GAP1;
				end else if (op_fmt && cur_trk != `DSF_LAST_TRK) begin
					nst = S_SEEK;
				end else begin
					nst = S_IDLE;
				end
			end
			default: ;
		endcase
		case (nst)
			S_IDM: begin
				ld_clk = `DSF_MARK_CLK;
				ld_byte = `DSF_IDM_DATA;
				ncrc = crc_upd(`DSF_CRC_INIT, `DSF_IDM_DATA);
			end
			S_ID: begin
				ld_byte = (nidx == 8'd0) ? {1'b0, cur_trk} : {3'b000, cur_sec};
				ncrc = crc_upd(crc, ld_byte);
			end
			S_IDC, S_DC: begin
				ld_byte = (nidx == 8'd0) ? crc[15:8] : crc[7:0];
			end
			S_DM: begin
				ld_clk = `DSF_MARK_CLK;
				ld_byte = `DSF_DM_DATA;
				ncrc = crc_upd(`DSF_CRC_INIT, `DSF_DM_DATA);
			end
			S_DAT: begin
				ld_byte = fill_now ? `DSF_FILL_BYTE : f_data[7:0];
				ncrc = crc_upd(crc, ld_byte);
			end
			default: ;
		endcase
	end
	// ----------------------------------------
	// read side
	// ----------------------------------------
	wire [15:0] rx_nx = {rx_sh[14:0], rd_s2};
	wire [7:0] rx_byte = fm_dat(rx_nx);
	wire [15:0] rcrc = crc_upd(crc, rx_byte);
	wire [15:0] idm_pat = fm_enc(`DSF_MARK_CLK, `DSF_IDM_DATA);
	wire [15:0] dm_pat = fm_enc(`DSF_MARK_CLK, `DSF_DM_DATA);
	wire rx_byte_in = cell_en && (bcnt == `DSF_BIT_LAST);
	wire bad_addr = (cmd_trk > `DSF_LAST_TRK) || (cmd_sec < `DSF_FIRST_SEC) || (cmd_sec > `DSF_SECTORS);
	// ----------------------------------------
	// main sequencer
	// ----------------------------------------
	always @(posedge clk_sys) begin
		if (srst) begin
			st <= {1'b0, S_IDLE};
			idx <= 8'd0;
			crc <= `DSF_CRC_INIT;
			sh <= 16'h0000;
			rx_sh <= 16'h0000;
			bcnt <= 4'h0;
			div <= 7'd0;
			cell_en <= 1'b0;
			{rd_s1, rd_s2, sk_s1, sk_s2} <= 4'h0;
			{op_rd, op_fmt, pad} <= 3'b000;
			cur_trk <= 7'd0;
			cur_sec <= 5'd1;
			cap_trk <= 8'h00;
			cap_sec <= 8'h00;
			rd_data <= 8'h00;
			{rd_valid, busy, done, rec_good, cmd_err} <= 5'h00;
			{id_crc_err, data_crc_err, underrun} <= 3'b000;
			seek_trk <= 7'd0;
			wr_cell <= 1'b0;
			wr_gate <= 1'b0;
		end else begin
			// pin synchronisers
			rd_s1 <= rd_cell;
			rd_s2 <= rd_s1;
			sk_s1 <= seek_ready;
			sk_s2 <= sk_s1;
			// half cell divider
			cell_en <= (div == CELL_TOP);
			div <= (div == CELL_TOP) ? 7'd0 : div + 7'd1;
			done <= 1'b0;
			rd_valid <= 1'b0;
			busy <= (st13 != S_IDLE) || hunt_dm;
			// cell shifting for both directions
			if (cell_en) begin
				bcnt <= bcnt + 4'h1;
				rx_sh <= rx_nx;
				wr_gate <= wr_st;
				if (wr_st) begin
					wr_cell <= sh[15];
					sh <= {sh[14:0], 1'b0};
				end else begin
					wr_cell <= 1'b0;
				end
			end
			// write stream byte loading
			if (load) begin
				st <= {1'b0, nst};
				idx <= nidx;
				crc <= ncrc;
				sh <= fm_enc(ld_clk, ld_byte);
				bcnt <= 4'h0;
				if (nst == S_DM) begin
					pad <= 1'b0;
				end
				if (f_pop && f_data[8]) begin
					pad <= 1'b1;
				end
				if (nst == S_DAT && !pad && !dummy && !f_valid) begin
					underrun <= 1'b1;
				end
				if (end_sec && op_fmt) begin
					if (cur_sec != `DSF_SECTORS) begin
						cur_sec <= cur_sec + 5'd1;
					end else begin
						cur_sec <= `DSF_FIRST_SEC;
						cur_trk <= cur_trk + 7'd1;
						seek_trk <= cur_trk + 7'd1;
					end
				end
				if (nst == S_IDLE) begin
					done <= 1'b1;
				end
			end
			// command start
			if (st13 == S_IDLE && !hunt_dm && (cmd_read || cmd_write || cmd_format)) begin
				{rec_good, cmd_err, id_crc_err, data_crc_err, underrun} <= 5'h00;
				pad <= 1'b0;
				idx <= 8'd0;
				op_rd <= cmd_read && !cmd_format;
				op_fmt <= cmd_format;
				if (cmd_format) begin
					cur_trk <= `DSF_INDEX_TRK;
					cur_sec <= `DSF_FIRST_SEC;
					seek_trk <= `DSF_INDEX_TRK;
					st <= {1'b0, S_SEEK};
				end else if (bad_addr) begin
					cmd_err <= 1'b1;
					done <= 1'b1;
				end else begin
					cur_trk <= cmd_trk;
					cur_sec <= cmd_sec;
					seek_trk <= cmd_trk;
					st <= {1'b0, S_SEEK};
				end
			end
			// count out the synchroniser delay after a move
			if (st13 == S_SEEK && idx != `DSF_SEEK_HOLD) begin
				idx <= idx + 8'd1;
			end
			// head in place for a read
			if (seek_ok && op_rd) begin
				st <= {1'b0, R_HUNT};
			end
			// hunt for an id mark, then collect the id field
			if (cell_en && st13 == R_HUNT && rx_nx == idm_pat) begin
				st <= {1'b0, R_ID};
				idx <= 8'd0;
				bcnt <= 4'h0;
				crc <= crc_upd(`DSF_CRC_INIT, `DSF_IDM_DATA);
			end
			if (rx_byte_in && st13 == R_ID) begin
				crc <= rcrc;
				idx <= idx + 8'd1;
				if (idx == 8'd0) begin
					cap_trk <= rx_byte;
				end
				if (idx == 8'd1) begin
					cap_sec <= rx_byte;
				end
				if (idx == `DSF_ID_LEN + `DSF_CRC_LEN - 8'd1) begin
					idx <= 8'd0;
					if (rcrc != `DSF_CRC_GOOD) begin
						id_crc_err <= 1'b1;
						st <= {1'b0, R_HUNT};
					end else if (cap_trk == {1'b0, cur_trk} && cap_sec == {3'b000, cur_sec}) begin
						st <= 14'h2000;
					end else begin
						st <= {1'b0, R_HUNT};
					end
				end
			end
			// wait for the data mark over the gap
			if (cell_en && hunt_dm) begin
				if (rx_nx == dm_pat) begin
					st <= {1'b0, R_DAT};
					idx <= 8'd0;
					bcnt <= 4'h0;
					crc <= crc_upd(`DSF_CRC_INIT, `DSF_DM_DATA);
				end else if (bcnt == `DSF_BIT_LAST) begin
					idx <= idx + 8'd1;
					if (idx == `DSF_DM_WAIT) begin
						st <= {1'b0, R_HUNT};
					end
				end
			end
			// data field bytes and check
			if (rx_byte_in && st13 == R_DAT) begin
				crc <= rcrc;
				idx <= idx + 8'd1;
				if (idx < `DSF_REC_LEN) begin
					rd_data <= rx_byte;
					rd_valid <= 1'b1;
				end
				if (idx == `DSF_REC_LEN + `DSF_CRC_LEN - 8'd1) begin
					if (rcrc == `DSF_CRC_GOOD) begin
						rec_good <= 1'b1;
					end else begin
						data_crc_err <= 1'b1;
					end
					done <= 1'b1;
					st <= {1'b0, S_IDLE};
				end
			end
			// abort wins over every state change and over the write gate
			if (cmd_abort) begin
				st <= {1'b0, S_IDLE};
				wr_gate <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// write buffer
	// ----------------------------------------
	dsf_fifo #(
		.W(`DSF_FIFO_W),
		.D(`DSF_FIFO_D),
		.AW(`DSF_FIFO_AW)
	) u_fifo (
		.clk_sys(clk_sys),
		.srst(srst),
		.in_data({in_last, in_data}),
		.in_valid(in_valid),
		.in_ready(in_ready),
		.out_data(f_data),
		.out_valid(f_valid),
		.out_ready(f_pop)
	);
endmodule
`default_nettype wire

// File: bench/dsf_drive_model.sv
// drive electronics model: head seek, read cell source, write cell decoder
`timescale 1ns/10ps
`default_nettype none
module dsf_drive_model (
	input wire logic clk_sys,
	input wire logic [6:0] seek_trk,
	output logic seek_ready,
	output logic rd_cell,
	input wire logic wr_cell,
	input wire logic wr_gate,
	output logic [15:0] wr_word,
	output logic wr_word_valid
);
	logic [6:0] pos_trk = 7'h00; // head position
	int settle = 0; // cycles left until the head settles
	logic [15:0] rd_q[$]; // clock/data byte pairs still to play
	logic [15:0] rd_sh = 16'hFFFF; // cells now playing
	logic [15:0] w; // next pair
	logic [15:0] wr_sh = 16'h0000; // gathered write cells
	int rd_n = 0, rd_ph = 0, wr_n = 0, wr_ph = 0;
	initial rd_cell = 1'b0;
	initial wr_word = 16'h0000;
	initial wr_word_valid = 1'b0;
	// ready falls in the very cycle the target moves away from the head
	assign seek_ready = (seek_trk == pos_trk) && (settle == 0);
	// step the head, then let it settle
	always @(posedge clk_sys) begin
		if (seek_trk != pos_trk) begin
			pos_trk <= seek_trk;
			settle <= 40;
		end else if (settle != 0) begin
			settle <= settle - 1;
		end
	end
	// the disk spins on: gap pairs fill in when nothing is queued
	always @(posedge clk_sys) begin
		rd_ph = (rd_ph + 1) % 100;
		if (rd_ph == 0) begin
			if (rd_n == 0) begin
				w = (rd_q.size() > 0) ? rd_q.pop_front() : 16'hFFFF;
				for (int i = 0; i < 8; i++) begin
					rd_sh[15-2*i] = w[15-i];
					rd_sh[14-2*i] = w[7-i];
				end
				rd_n = 16;
			end
			rd_cell <= rd_sh[15];
			rd_sh = rd_sh << 1;
			rd_n = rd_n - 1;
		end
	end
	// sample each write cell in its middle, clock cell first
	always @(posedge clk_sys) begin
		wr_word_valid <= 1'b0;
		if (wr_gate !== 1'b1) begin
			wr_ph = 0;
			wr_n = 0;
		end else begin
			wr_ph = wr_ph + 1;
			if (wr_ph % 100 == 50) begin
				wr_sh = {wr_sh[14:0], wr_cell};
				wr_n = wr_n + 1;
				if (wr_n == 16) begin
					wr_n = 0;
					for (int i = 0; i < 8; i++) begin
						wr_word[15-i] <= wr_sh[15-2*i];
						wr_word[7-i] <= wr_sh[14-2*i];
					end
					wr_word_valid <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: bench/dsf_framer_sva.sv
// assertions on the ports of the sector framer
`timescale 1ns/10ps
`default_nettype none
module dsf_framer_sva (
	input wire clk_sys,
	input wire srst,
	input wire cmd_read,
	input wire cmd_write,
	input wire cmd_format,
	input wire [6:0] cmd_trk,
	input wire [4:0] cmd_sec,
	input wire in_ready,
	input wire rd_valid,
	input wire busy,
	input wire done,
	input wire rec_good,
	input wire cmd_err,
	input wire id_crc_err,
	input wire data_crc_err,
	input wire underrun,
	input wire [6:0] seek_trk,
	input wire wr_cell,
	input wire wr_gate
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	wire take_rw = (cmd_read || cmd_write) && !busy; // addressed command taken
	wire take_any = take_rw || (cmd_format && !busy); // any command taken
	wire legal = cmd_trk <= 7'd76 && cmd_sec >= 5'd1 && cmd_sec <= 5'd26;
	logic [6:0] cap_trk; // target of the last addressed command
	logic [7:0] n_rd; // read bytes handed out since the command
	int unsigned gap; // cycles since the last cell change or rise of the write gate
	// helper counters
	always @(posedge clk_sys) begin
		if (srst) begin
			cap_trk <= 7'h00;
			n_rd <= 8'h00;
			gap <= 0;
		end else begin
			if (take_rw) cap_trk <= cmd_trk;
			if (take_rw) n_rd <= 8'h00;
			else if (rd_valid) n_rd <= n_rd + 8'h01;
			gap <= ($changed(wr_cell) || $rose(wr_gate)) ? 0 : gap + 1;
		end
	end
	chk_trk_range: assert property (take_rw && cmd_trk > 7'd76 |-> ##[1:2] (done && cmd_err))
		else $error("track beyond the last not refused");
	chk_sec_range: assert property (take_rw && (cmd_sec == 5'd0 || cmd_sec > 5'd26) |-> ##[1:2] (done && cmd_err))
		else $error("sector outside 1 to 26 not refused");
	chk_seek_target: assert property (take_rw && legal |-> ##[1:2] (busy && !cmd_err && seek_trk == cap_trk))
		else $error("legal command not started on its track");
	chk_flags_clear: assert property (take_any |-> ##[1:2] !(rec_good || id_crc_err || data_crc_err || underrun))
		else $error("status not cleared by a new command");
	chk_good_excl: assert property (rec_good |-> !data_crc_err)
		else $error("record good despite a check error");
	chk_rec_len: assert property (done && rec_good |-> n_rd == 8'd128)
		else $error("good record without 128 bytes");
	chk_rd_max: assert property (rd_valid |-> n_rd < 8'd128)
		else $error("more than 128 bytes read");
	chk_rd_pulse: assert property (rd_valid |=> !rd_valid [*8])
		else $error("read bytes too close");
	chk_cell_rate: assert property ($changed(wr_cell) && wr_gate && $past(wr_gate) |-> (gap % 100) == 99)
		else $error("write cell off the cell grid");
	chk_reset_state: assert property (disable iff (1'b0) srst |=> (in_ready && !busy && !done && !wr_gate && !rd_valid))
		else $error("outputs not at rest after reset");
endmodule
bind dsf_framer dsf_framer_sva chk_u (.clk_sys(clk_sys), .srst(srst), .cmd_read(cmd_read), .cmd_write(cmd_write),
	.cmd_format(cmd_format), .cmd_trk(cmd_trk), .cmd_sec(cmd_sec), .in_ready(in_ready), .rd_valid(rd_valid),
	.busy(busy), .done(done), .rec_good(rec_good), .cmd_err(cmd_err), .id_crc_err(id_crc_err),
	.data_crc_err(data_crc_err), .underrun(underrun), .seek_trk(seek_trk), .wr_cell(wr_cell), .wr_gate(wr_gate));
`default_nettype wire

// File: bench/dsf_framer_tb.sv
// self-checking testbench of the sector framer
`timescale 1ns/10ps
`default_nettype none
module dsf_framer_tb;
	logic clk_sys, srst, cmd_read, cmd_write, cmd_format, cmd_abort;
	logic [6:0] cmd_trk, seek_trk, trk;
	logic [4:0] cmd_sec, sec;
	logic [7:0] in_data, rd_data;
	logic in_last, in_valid, in_ready, rd_valid, busy, done, rec_good, cmd_err;
	logic [7:0] dat_q[$]; // read bytes still expected
	logic id_crc_err, data_crc_err, underrun, seek_ready, rd_cell, wr_cell, wr_gate, wr_word_valid;
	logic [15:0] wr_word, crc;
	logic [15:0] exp_q[$]; // wire pairs still expected
	logic err_q[$]; // error flag expected at each done
	logic [7:0] d[4]; // record bytes
	logic [6:0] bad_t[4] = '{7'h4D, 7'h4C, 7'h4C, 7'h7F}; // refused targets
	logic [4:0] bad_s[4] = '{5'h01, 5'h00, 5'h1B, 5'h1A};
	int n_fail = 0, n_compared = 0, seed = 32'h046C, k;
	dsf_framer dut_u (.clk_sys(clk_sys), .srst(srst), .cmd_read(cmd_read), .cmd_write(cmd_write),
		.cmd_format(cmd_format), .cmd_abort(cmd_abort), .cmd_trk(cmd_trk), .cmd_sec(cmd_sec), .in_data(in_data),
		.in_last(in_last), .in_valid(in_valid), .in_ready(in_ready), .rd_data(rd_data), .rd_valid(rd_valid),
		.busy(busy), .done(done), .rec_good(rec_good), .cmd_err(cmd_err), .id_crc_err(id_crc_err),
		.data_crc_err(data_crc_err), .underrun(underrun), .seek_trk(seek_trk), .seek_ready(seek_ready),
		.rd_cell(rd_cell), .wr_cell(wr_cell), .wr_gate(wr_gate));
	dsf_drive_model drv_u (.clk_sys(clk_sys), .seek_trk(seek_trk), .seek_ready(seek_ready), .rd_cell(rd_cell),
		.wr_cell(wr_cell), .wr_gate(wr_gate), .wr_word(wr_word), .wr_word_valid(wr_word_valid));
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	task check(input logic [15:0] seen, input logic [15:0] want);
		n_compared++;
		if (seen !== want) begin
			n_fail++;
			$display("BAD t=%0t seen %h want %h", $time, seen, want);
		end
	endtask
	task complete_run;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// preset ones, x16+x12+x5+1, msb first
	function logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
		return c;
	endfunction
	// 0: pairs used up, 1: id error, 2: refusal seen, 3: idle, 4: second id playing, 5: read bytes seen
	task wait_until(input int what, input int lim);
		for (int i = 0; i < lim; i++) begin
			@(posedge clk_sys);
			#1;
			if ((what == 0 && exp_q.size() == 0) || (what == 1 && id_crc_err === 1'b1) || (what == 2 && err_q.size() == 0)
				|| (what == 3 && busy === 1'b0) || (what == 4 && drv_u.rd_q.size() < 14)
				|| (what == 5 && dat_q.size() == 0)) return;
		end
		$display("BAD t=%0t wait %h timed out", $time, what);
		n_fail++;
		complete_run;
	endtask
	task cmd(input int kind, input logic [6:0] t, input logic [4:0] s);
		@(negedge clk_sys);
		cmd_trk = t;
		cmd_sec = s;
		{cmd_format, cmd_write, cmd_read} = 3'b001 << kind;
		@(negedge clk_sys);
		{cmd_format, cmd_write, cmd_read} = 3'b000;
	endtask
	task abort;
		@(negedge clk_sys);
		cmd_abort = 1'b1;
		@(negedge clk_sys);
		cmd_abort = 1'b0;
		wait_until(3, 200);
	endtask
	task push(input logic [7:0] b, input logic l);
		@(negedge clk_sys);
		in_data = b;
		in_last = l;
		in_valid = 1'b1;
		// ready is looked at where it has settled; the next rising edge takes the byte
		for (int i = 0; in_ready !== 1'b1; i++) begin
			if (i == 20) wait_until(6, 0);
			@(negedge clk_sys);
		end
		@(negedge clk_sys);
		in_valid = 1'b0;
	endtask
	// one gap pair (drive side only), then mark, track, sector, check pair
	task id_field(input logic [6:0] t, input logic [4:0] s, input logic [15:0] flip, input int to_wire);
		crc = crc_step(crc_step(crc_step(16'hFFFF, 8'hFE), {1'b0, t}), {3'b000, s}) ^ flip;
		if (to_wire == 0) begin
			drv_u.rd_q.push_back(16'hFFFF);
			drv_u.rd_q.push_back(16'hC7FE);
			drv_u.rd_q.push_back({9'h1FE, t});
			drv_u.rd_q.push_back({11'h7F8, s});
			drv_u.rd_q.push_back({8'hFF, crc[15:8]});
			drv_u.rd_q.push_back({8'hFF, crc[7:0]});
		end else begin
			exp_q.push_back(16'hC7FE);
			exp_q.push_back({9'h1FE, t});
			exp_q.push_back({11'h7F8, s});
			exp_q.push_back({8'hFF, crc[15:8]});
			exp_q.push_back({8'hFF, crc[7:0]});
		end
	endtask
	// oldest note against each result that appears
	always @(negedge clk_sys) begin
		if (wr_word_valid === 1'b1 && exp_q.size() > 0) check(wr_word, exp_q.pop_front());
		if (done === 1'b1 && err_q.size() > 0) check({15'h0000, cmd_err}, {15'h0000, err_q.pop_front()});
		if (rd_valid === 1'b1 && dat_q.size() > 0) check({8'h00, rd_data}, {8'h00, dat_q.pop_front()});
	end
	initial begin
		{srst, cmd_read, cmd_write, cmd_format, cmd_abort, in_last, in_valid} = 7'h40;
		{cmd_trk, cmd_sec, in_data} = 20'h00000;
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		srst = 1'b0;
		for (k = 0; k < 4; k++) begin
			err_q.push_back(1'b1);
			cmd(k % 2, bad_t[k], bad_s[k]);
			wait_until(2, 10);
		end
		$display("test refusal ended");
		cmd(0, 7'h4C, 5'h1A);
		repeat (3) @(posedge clk_sys);
		#1 check({9'h000, seek_trk}, 16'h004C);
		abort;
		$display("test last sector ended");
		trk = 7'd1 + 7'({$random(seed)} % 73);
		sec = 5'd1 + 5'({$random(seed)} % 26);
		d[0] = 8'($random(seed));
		cmd(0, trk, sec);
		id_field(trk, (sec == 5'd26) ? 5'd1 : sec + 5'd1, 16'h0000, 0);
		id_field(trk, sec, 16'h0100, 0);
		// a copy with a good id follows, its data mark right behind the id, then a single data byte
		id_field(trk, sec, 16'h0000, 0);
		drv_u.rd_q.push_back(16'hC7FB);
		drv_u.rd_q.push_back({8'hFF, d[0]});
		dat_q.push_back(d[0]);
		wait_until(4, 12000);
		check({15'h0000, id_crc_err}, 16'h0000);
		wait_until(1, 14000);
		check({15'h0000, busy}, 16'h0001);
		wait_until(5, 14000);
		check({15'h0000, rec_good}, 16'h0000);
		abort;
		$display("test read check error ended");
		for (k = 0; k < 4; k++) begin
			d[k] = $random(seed);
			push(d[k], k == 3);
		end
		@(posedge clk_sys);
		#1 check({15'h0000, in_ready}, 16'h0000);
		repeat (17) exp_q.push_back(16'hFFFF);
		id_field(trk, sec, 16'h0000, 1);
		repeat (17) exp_q.push_back(16'hFFFF);
		exp_q.push_back(16'hC7FB);
		for (k = 0; k < 4; k++) exp_q.push_back({8'hFF, d[k]});
		exp_q.push_back(16'hFF00);
		cmd(1, trk, sec);
		wait_until(0, 80000);
		check({15'h0000, underrun}, 16'h0000);
		abort;
		$display("test write ended");
		cmd(2, 7'h00, 5'h00);
		repeat (3) @(posedge clk_sys);
		#1 check({9'h000, seek_trk}, 16'h0000);
		abort;
		$display("test format start ended");
		complete_run;
	end
endmodule
`default_nettype wire
